// >>> hw/mfb_buf2.v
// two-entry command buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module mfb_buf2 #(
  parameter W = 8
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  output wire out_valid_o,
  output wire [W-1:0] out_data_o,
  input wire out_ready_i,
  output wire [1:0] level_o
);

  reg [W-1:0] slot_r [0:1];
  reg [1:0] level_r;
  reg valid_r;
  wire [1:0] level_nxt;
  wire push;
  wire pop;
  integer i;

  // ------------------------------------------------------------------
  // handshakes
  // ------------------------------------------------------------------
  assign in_ready_o = (level_r != 2'h2);
  // valid has its own flop so the consumer never sees a decoded strobe
  assign out_valid_o = valid_r;
  assign level_nxt = level_r + {1'b0, push} - {1'b0, pop};
  assign out_data_o = slot_r[0];
  assign level_o = level_r;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;

  // slot 0 is always the head so the consumer sees a flop directly
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      level_r <= 2'h0;
      valid_r <= 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
        slot_r[i] <= {W{1'b0}};
      end
    end else begin
      level_r <= level_nxt;
      valid_r <= (level_nxt != 2'h0);
      if (pop) begin
        slot_r[0] <= slot_r[1];
      end
      if (push) begin
        // new word lands behind whatever survives this edge
        if (level_r == 2'h0 || (level_r == 2'h1 && pop)) begin
          slot_r[0] <= in_data_i;
        end else begin
          slot_r[1] <= in_data_i;
        end
      end
    end
  end

endmodule // mfb_buf2

`default_nettype wire

// >>> hw/mfb_defs.vh
// constants for the memory-mapped slave flow, pipeline and burst block
`ifndef MFB_DEFS_VH
`define MFB_DEFS_VH

// ------------------------------------------------------------------
// response codes on the shared two-bit answer bus
// ------------------------------------------------------------------
`define MFB_RESP_OK 2'h0
`define MFB_RESP_RSVD 2'h1
`define MFB_RESP_FAIL 2'h2
`define MFB_RESP_UNMAP 2'h3

// ------------------------------------------------------------------
// default widths and command buffer depth
// ------------------------------------------------------------------
`define MFB_DATA_W 32
`define MFB_BURST_W 4
`define MFB_OUTST_W 8
`define MFB_BUF_DEPTH 2

`endif

// >>> hw/mfb_slave_flow.v
// memory-mapped slave front end: stall, pipelined reads, write responses
`timescale 1ns/1ps
`default_nettype none
`include "mfb_defs.vh"

// Operation
// - raise stall whenever the current read or write cannot be taken.
// - stall may stay high in idle cycles with nothing pending.
// - stall is held high throughout reset to avoid lockup.
// - one read-valid pulse per returned word; burst of n gives n.
// - read-valid never in the cycle the read command is taken.
// - read data may return even while new commands are stalled.
// - pipelined and bursting read interfaces carry the read-valid strobe.
// - each write gets a response, no earlier than one clock after.
// - burst length field 1 to 11 bits, counting transfers.
// - burst length at least one; maximum burst a power of two.
// - address width covers burst width plus log2 symbols per word.
// - burst start found by counting write beats, not by the marker.
// - everything runs on one input clock.
// - response codes 00 ok, 01 reserved, 10 failure, 11 unmapped.
// - one response code per read word, even on error.
// - one write response per burst, after its final beat is taken.
// - active-low stall and read-valid copies are offered too.
module mfb_slave_flow #(
  parameter DATA_W = `MFB_DATA_W,
  parameter BURST_W = `MFB_BURST_W,
  parameter OUTST_W = `MFB_OUTST_W
) (
  input wire sys_clk_i,
  input wire nrst_i,
  input wire m_read_i,
  input wire m_write_i,
  input wire [BURST_W-1:0] m_burst_len_i,
  input wire [DATA_W-1:0] m_wr_data_i,
  output wire m_stall_o,
  output wire m_stall_n_o,
  output wire m_rd_valid_o,
  output wire m_rd_valid_n_o,
  output wire [DATA_W-1:0] m_rd_data_o,
  output wire [1:0] m_resp_o,
  output wire m_wr_resp_valid_o,
  output wire c_cmd_valid_o,
  input wire c_cmd_ready_i,
  output wire c_cmd_write_o,
  output wire c_cmd_last_o,
  output wire [BURST_W-1:0] c_cmd_len_o,
  output wire [DATA_W-1:0] c_cmd_data_o,
  input wire c_rd_valid_i,
  input wire [DATA_W-1:0] c_rd_data_i,
  input wire [1:0] c_rd_resp_i,
  input wire c_wr_done_i,
  input wire [1:0] c_wr_resp_i,
  output wire c_wr_hold_o
);

  localparam ENT_W = DATA_W + BURST_W + 2;
  // headroom so a whole maximum burst always fits in the read counter
  localparam [OUTST_W-1:0] RD_LIMIT =
    {OUTST_W{1'b1}} - {{(OUTST_W-BURST_W){1'b0}}, {BURST_W{1'b1}}};
  // narrowest word address a bursting neighbour may use with this length
  localparam ADDR_W_MIN = BURST_W;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  reg stall_r;
  reg stall_n_r;
  reg rd_valid_r;
  reg rd_valid_n_r;
  reg [DATA_W-1:0] rd_data_r;
  reg [1:0] resp_r;
  reg wr_resp_valid_r;
  reg [OUTST_W-1:0] rd_outst_r;
  reg [OUTST_W-1:0] rd_outst_nxt;
  reg [BURST_W-1:0] wr_left_r;
  reg [BURST_W-1:0] wr_left_nxt;
  reg [OUTST_W-1:0] wr_bursts_r;
  reg [OUTST_W-1:0] wr_bursts_nxt;
  reg wr_pend_r;
  reg [1:0] wr_pend_code_r;
  reg wr_last;
  reg [BURST_W-1:0] eff_len;
  reg rd_ret;
  reg wr_take;
  reg wr_issue;
  reg [1:0] wr_code;
  reg [1:0] lvl_nxt;

  wire rd_acc;
  wire wr_acc;
  wire buf_in_valid;
  wire buf_in_ready;
  wire [ENT_W-1:0] buf_in_data;
  wire [ENT_W-1:0] buf_out_data;
  wire buf_out_valid;
  wire [1:0] buf_level;

  // ------------------------------------------------------------------
  // acceptance and buffer entry
  // ------------------------------------------------------------------
  // a request counts only on an edge where stall is low
  assign rd_acc = m_read_i & ~stall_r;
  assign wr_acc = m_write_i & ~m_read_i & ~stall_r;
  assign buf_in_valid = rd_acc | wr_acc;
  assign buf_in_data = {wr_acc, wr_last, eff_len, m_wr_data_i};

  // burst tracking by beat counting; the legacy marker is never looked at
  always @* begin
    // a zero length is illegal, so treat it as a single beat
    eff_len = (m_burst_len_i == {BURST_W{1'b0}}) ?
      {{(BURST_W-1){1'b0}}, 1'b1} : m_burst_len_i;
    wr_last = 1'b0;
    wr_left_nxt = wr_left_r;
    if (wr_acc) begin
      if (wr_left_r == {BURST_W{1'b0}}) begin
        // first beat of a new write burst
        wr_left_nxt = eff_len - {{(BURST_W-1){1'b0}}, 1'b1};
        wr_last = (wr_left_nxt == {BURST_W{1'b0}});
      end else begin
        wr_left_nxt = wr_left_r - {{(BURST_W-1){1'b0}}, 1'b1};
        wr_last = (wr_left_nxt == {BURST_W{1'b0}});
      end
    end
  end

  mfb_buf2 #(
    .W(ENT_W)
  ) u_cmd_buf (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .in_valid_i(buf_in_valid),
    .in_data_i(buf_in_data),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_out_valid),
    .out_data_o(buf_out_data),
    .out_ready_i(c_cmd_ready_i),
    .level_o(buf_level)
  );

  // ------------------------------------------------------------------
  // answer bookkeeping
  // ------------------------------------------------------------------
  always @* begin
    // read words only pass while beats are owed
    rd_ret = c_rd_valid_i & (rd_outst_r != {OUTST_W{1'b0}});
    rd_outst_nxt = rd_outst_r
      + (rd_acc ? {{(OUTST_W-BURST_W){1'b0}}, eff_len} : {OUTST_W{1'b0}})
      - {{(OUTST_W-1){1'b0}}, rd_ret};
    // write completions only count while a finished burst is owed
    wr_take = c_wr_done_i & ~wr_pend_r &
      (wr_bursts_r != {OUTST_W{1'b0}});
    // the shared answer bus gives reads priority over writes
    wr_issue = ~rd_ret & (wr_pend_r | wr_take);
    wr_code = wr_pend_r ? wr_pend_code_r : c_wr_resp_i;
    wr_bursts_nxt = wr_bursts_r
      + {{(OUTST_W-1){1'b0}}, (wr_acc & wr_last)}
      - {{(OUTST_W-1){1'b0}}, wr_issue};
    lvl_nxt = buf_level + {1'b0, buf_in_valid & buf_in_ready}
      - {1'b0, buf_out_valid & c_cmd_ready_i};
  end

  // counters and the parked write answer
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rd_outst_r <= {OUTST_W{1'b0}};
      wr_left_r <= {BURST_W{1'b0}};
      wr_bursts_r <= {OUTST_W{1'b0}};
      wr_pend_r <= 1'b0;
      wr_pend_code_r <= `MFB_RESP_OK;
    end else begin
      rd_outst_r <= rd_outst_nxt;
      wr_left_r <= wr_left_nxt;
      wr_bursts_r <= wr_bursts_nxt;
      if (wr_issue) begin
        wr_pend_r <= 1'b0;
      end else if (wr_take) begin
        // collided with a read word, so park it for a free cycle
        wr_pend_r <= 1'b1;
        wr_pend_code_r <= c_wr_resp_i;
      end
    end
  end

  // ------------------------------------------------------------------
  // master-facing outputs, all registered
  // ------------------------------------------------------------------
  // registering the answers keeps them at least one edge after acceptance
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      stall_r <= 1'b1;
      stall_n_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_valid_n_r <= 1'b1;
      rd_data_r <= {DATA_W{1'b0}};
      resp_r <= `MFB_RESP_OK;
      wr_resp_valid_r <= 1'b0;
    end else begin
      // stall when the buffer or the read counter cannot take another
      stall_r <= (lvl_nxt == 2'h2) || (rd_outst_nxt > RD_LIMIT);
      stall_n_r <= ~((lvl_nxt == 2'h2) || (rd_outst_nxt > RD_LIMIT));
      rd_valid_r <= rd_ret;
      rd_valid_n_r <= ~rd_ret;
      rd_data_r <= c_rd_data_i;
      wr_resp_valid_r <= wr_issue;
      if (rd_ret) begin
        resp_r <= c_rd_resp_i;
      end else if (wr_issue) begin
        resp_r <= wr_code;
      end else begin
        resp_r <= `MFB_RESP_OK;
      end
    end
  end

  assign m_stall_o = stall_r;
  assign m_stall_n_o = stall_n_r;
  assign m_rd_valid_o = rd_valid_r;
  assign m_rd_valid_n_o = rd_valid_n_r;
  assign m_rd_data_o = rd_data_r;
  assign m_resp_o = resp_r;
  assign m_wr_resp_valid_o = wr_resp_valid_r;
  assign c_cmd_valid_o = buf_out_valid;
  assign c_cmd_write_o = buf_out_data[ENT_W-1];
  assign c_cmd_last_o = buf_out_data[ENT_W-2];
  assign c_cmd_len_o = buf_out_data[DATA_W+BURST_W-1:DATA_W];
  assign c_cmd_data_o = buf_out_data[DATA_W-1:0];
  assign c_wr_hold_o = wr_pend_r;

endmodule // mfb_slave_flow

`default_nettype wire

// >>> verif/mfb_chk_checker.sv
// checker: port assertions for the slave front end
`timescale 1ns/1ps
`default_nettype none
module mfb_chk (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic m_read_i,
  input wire logic m_write_i,
  input wire logic m_stall_o,
  input wire logic m_stall_n_o,
  input wire logic m_rd_valid_o,
  input wire logic m_rd_valid_n_o,
  input wire logic [31:0] m_rd_data_o,
  input wire logic [1:0] m_resp_o,
  input wire logic m_wr_resp_valid_o,
  input wire logic c_cmd_valid_o,
  input wire logic c_cmd_ready_i,
  input wire logic c_rd_valid_i,
  input wire logic [31:0] c_rd_data_i,
  input wire logic [1:0] c_rd_resp_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // reset must not be masked here, so this one overrides the default
  stall_in_rst_a: assert property (
    disable iff (1'b0) !nrst_i |=> m_stall_o) else $error("stall low");
  stall_pair_a: assert property (
    m_stall_n_o == !m_stall_o) else $error("stall copies differ");
  rdv_pair_a: assert property (
    m_rd_valid_n_o == !m_rd_valid_o) else $error("valid copies differ");
  resp_shared_a: assert property (
    !(m_rd_valid_o && m_wr_resp_valid_o)) else $error("two answers");
  resp_idle_a: assert property (
    !m_rd_valid_o && !m_wr_resp_valid_o |-> m_resp_o == 2'h0)
    else $error("resp not idle");
  rd_echo_a: assert property (
    m_rd_valid_o |-> $past(c_rd_valid_i) && m_resp_o == $past(c_rd_resp_i)
    && m_rd_data_o == $past(c_rd_data_i)) else $error("bad read word");
  accept_fwd_a: assert property (
    (m_read_i || m_write_i) && !m_stall_o |-> ##1 c_cmd_valid_o)
    else $error("accepted request lost");
  cmd_hold_a: assert property (
    c_cmd_valid_o && !c_cmd_ready_i |=> c_cmd_valid_o)
    else $error("command dropped");
  rd_seen_c: cover property (m_rd_valid_o);
  wr_seen_c: cover property (m_wr_resp_valid_o);
  stall_req_c: cover property (m_read_i && m_stall_o);
endmodule // mfb_chk
bind mfb_slave_flow mfb_chk u_chk (.*);
`default_nettype wire

// >>> verif/mfb_core_model.sv
// model: core behind the front end, answers reads and write bursts
`timescale 1ns/1ps
`default_nettype none
module mfb_core_model (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic valid_i,
  input wire logic write_i,
  input wire logic last_i,
  input wire logic [3:0] len_i,
  input wire logic stall_i,
  input wire logic [1:0] code_i,
  input wire logic hold_i,
  output logic ready_o,
  output logic rd_valid_o = 1'b0,
  output logic [31:0] rd_data_o = 32'h0,
  output logic [1:0] rd_resp_o = 2'h0,
  output logic done_o = 1'b0,
  output logic [1:0] wr_resp_o = 2'h0
);
  logic [7:0] owe_r = 8'h0;
  logic [3:0] wd_r = 4'h0;
  logic [31:0] seq_r = 32'h100;
  logic acc, rd_go, wr_go;
  // back pressure comes only from the bench's stall request
  assign ready_o = !stall_i;
  assign acc = valid_i && ready_o;
  assign rd_go = owe_r != 8'h0;
  assign wr_go = !rd_go && wd_r != 4'h0 && !hold_i;
  // idle lines flip so a stale word is never mistaken for fresh data
  always @(posedge sys_clk_i) begin
    rd_valid_o <= rd_go && nrst_i;
    done_o <= wr_go && nrst_i;
    rd_data_o <= rd_go ? seq_r : ~rd_data_o;
    rd_resp_o <= rd_go ? code_i : ~rd_resp_o;
    wr_resp_o <= wr_go ? code_i : ~wr_resp_o;
    if (!nrst_i) begin
      owe_r <= 8'h0;
      wd_r <= 4'h0;
    end else begin
      seq_r <= seq_r + {31'h0, rd_go};
      owe_r <= owe_r - {7'h0, rd_go} + ((acc && !write_i) ?
        ((len_i == 4'h0) ? 8'h1 : {4'h0, len_i}) : 8'h0);
      wd_r <= wd_r - {3'h0, wr_go} + {3'h0, acc && write_i && last_i};
    end
  end
endmodule // mfb_core_model
`default_nettype wire

// >>> verif/mfb_slave_flow_tb.sv
// testbench: bursts, response codes and stall of the front end
`timescale 1ns/1ps
`default_nettype none
module mfb_slave_flow_tb;
  logic sys_clk_i, nrst_i, m_read_i, m_write_i, core_stall;
  logic [3:0] m_burst_len_i, c_cmd_len_o;
  logic [31:0] m_wr_data_i, m_rd_data_o, c_cmd_data_o, c_rd_data_i;
  logic [1:0] m_resp_o, c_rd_resp_i, c_wr_resp_i, code;
  logic m_stall_o, m_stall_n_o, m_rd_valid_o, m_rd_valid_n_o;
  logic m_wr_resp_valid_o, c_cmd_valid_o, c_cmd_ready_i, c_cmd_write_o;
  logic c_cmd_last_o, c_rd_valid_i, c_wr_done_i, c_wr_hold_o;
  int num_errors = 0, n_tests = 0, nw = 0, nwr = 0, cyc = 0, nb = 0, w0, e;
  // rows: {code, burst length, words expected}; length 0 gives one beat
  logic [9:0] rows [5] = '{10'h011, 10'h244, 10'h288, 10'h388, 10'h301};
  mfb_slave_flow dut (.*);
  mfb_core_model core (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .valid_i(c_cmd_valid_o), .write_i(c_cmd_write_o),
    .last_i(c_cmd_last_o), .len_i(c_cmd_len_o), .stall_i(core_stall),
    .code_i(code), .hold_i(c_wr_hold_o), .ready_o(c_cmd_ready_i),
    .rd_valid_o(c_rd_valid_i), .rd_data_o(c_rd_data_i),
    .rd_resp_o(c_rd_resp_i), .done_o(c_wr_done_i),
    .wr_resp_o(c_wr_resp_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // request stays put through any stall, dropped after the taking edge
  task automatic req(input logic w, input logic [3:0] len,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    m_read_i <= !w;
    m_write_i <= w;
    m_burst_len_i <= len;
    m_wr_data_i <= d;
    @(negedge sys_clk_i);
    while (m_stall_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    m_read_i <= 1'b0;
    m_write_i <= 1'b0;
  endtask
  // answers are watched mid-cycle, away from the register updates
  always @(negedge sys_clk_i) begin
    if (m_rd_valid_o) begin
      chk(m_rd_data_o, 32'h100 + nw);
      chk(m_resp_o, code);
      nw++;
    end
    if (m_wr_resp_valid_o) begin
      chk(m_resp_o, code);
      nwr++;
    end
    // every write handed to the core carries the offered data and the burst length in beats; reads only have last checked low
    if (c_cmd_valid_o && c_cmd_ready_i) begin
      if (c_cmd_write_o) begin
        chk(c_cmd_data_o, 32'ha0 + nb);
        chk(c_cmd_len_o, e);
        chk(c_cmd_last_o, nb == e - 1);
        nb = (nb == e - 1) ? 0 : nb + 1;
      end else begin
        chk(c_cmd_last_o, 1'b0);
      end
    end
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      close_out;
    end
  end
  initial begin
    {nrst_i, m_read_i, m_write_i, core_stall, code} = 6'h0;
    {m_burst_len_i, m_wr_data_i} = 36'h0;
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    chk(m_stall_o, 1);
    @(posedge sys_clk_i) nrst_i <= 1'b1;
    foreach (rows[i]) begin
      e = rows[i][3:0];
      @(posedge sys_clk_i) code <= rows[i][9:8];
      w0 = nw;
      req(1'b0, rows[i][7:4], 32'h0);
      repeat (20) @(negedge sys_clk_i);
      chk(nw - w0, e);
      w0 = nwr;
      for (int b = 0; b < e; b++) req(1'b1, rows[i][7:4], 32'ha0 + b);
      repeat (20) @(negedge sys_clk_i);
      chk(nwr - w0, 1);
    end
    // core stalls: two commands fill the buffer, the third must wait
    @(posedge sys_clk_i) core_stall <= 1'b1;
    w0 = nw;
    req(1'b0, 4'h1, 32'h0);
    req(1'b0, 4'h2, 32'h0);
    fork
      req(1'b0, 4'h1, 32'h0);
      begin
        repeat (4) @(negedge sys_clk_i);
        chk(m_stall_o, 1);
        chk(nw, w0);
        @(posedge sys_clk_i) core_stall <= 1'b0;
      end
    join
    repeat (20) @(negedge sys_clk_i);
    chk(nw - w0, 4);
    chk(c_wr_hold_o, 1'b0);
    // reset in mid-run: stall rises, nothing is offered, then work resumes
    @(posedge sys_clk_i) nrst_i <= 1'b0;
    repeat (2) @(negedge sys_clk_i);
    chk(m_stall_o, 1'b1);
    chk(m_rd_valid_o, 1'b0);
    chk(c_cmd_valid_o, 1'b0);
    @(posedge sys_clk_i) nrst_i <= 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk(m_stall_o, 1'b0);
    w0 = nw;
    req(1'b0, 4'h2, 32'h0);
    repeat (20) @(negedge sys_clk_i);
    chk(nw - w0, 2);
    close_out;
  end
endmodule // mfb_slave_flow_tb
`default_nettype wire
